// file: include/codec_map.svh
`ifndef CODEC_MAP_SVH
`define CODEC_MAP_SVH

// factor object selectors on the object port
`define SEL_S16_SPEED     3'h0
`define SEL_S16_POSITION  3'h1
`define SEL_S16_VOLTAGE   3'h2
`define SEL_S32_SPEED     3'h3
`define SEL_S32_POSITION  3'h4
`define SEL_S32_VOLTAGE   3'h5
`define SEL_COUNT         3'h6

// normalization-factor word layout
`define FAC_BASE_BIT      5
`define FAC_EXP_MSB       4
`define FAC_WRITE_MASK    16'h003F
`define FAC_RST           16'h0000
`define DEC_EXP_MAX       5'h09
`define BIN_EXP_MAX       5'h18

// internal values are signed Q32.32
`define Q_FRAC            6'h20
`define FIX16_FRAC        6'h06
`define K_ONE             34'h000000001
`define K_Q_ONE           34'h100000000
`define K_FIX16_DEC       34'h004000000
`define K_MILLI_DEC       34'h000418937
`define K_MILLI_ENC       34'h0000003E8

`endif

// file: include/codec_pkg.sv
package codec_pkg;

    // bus formats handled by the codec
    typedef enum logic [3:0] {
        INT8           = 4'b0000,
        INT16          = 4'b0001,
        INT32          = 4'b0010,
        UINT8          = 4'b0011,
        UINT16         = 4'b0100,
        UINT32         = 4'b0101,
        FIXED16_SIX    = 4'b0110,
        FIXED32_MILLI  = 4'b0111,
        SCALED_INT16   = 4'b1000,
        SCALED_INT32   = 4'b1001,
        BIT_STRING16   = 4'b1010
    } fmt_t;

    // whole state of the codec top
    typedef struct packed {
        logic [5:0][15:0] fac;
        logic [15:0]      rd_data;
        logic             rd_vld;
        logic             s1_vld;
        logic             s1_enc;
        fmt_t             s1_fmt;
        logic [63:0]      s1_a;
        logic [33:0]      s1_k;
        logic [5:0]       s1_sh;
        logic             s1_err;
        logic             res_vld;
        logic             res_err;
        logic [63:0]      res;
        logic [15:0]      bus_first;
        logic [15:0]      bus_second;
        logic             oct_open;
        logic [7:0]       oct_left;
        logic             oct_vld;
        logic             oct_last;
        logic [7:0]       oct_byte;
        logic             oct_err;
    } codec_state_t;

endpackage : codec_pkg

// file: logic/scale_mul.sv
// signed multiply then arithmetic shift; one multiplier serves both directions
module scale_mul (
    // operands
    input  wire logic signed [63:0] a,
    input  wire logic signed [33:0] k,
    input  wire logic        [5:0]  sh,
    // result, low 64 bits of the shifted product
    output logic             [63:0] y
);
    logic signed [97:0] prod;
    logic signed [97:0] shifted;

    // full-width product so no magnitude bits are lost before the shift
    always_comb begin
        prod    = a * k;
        shifted = prod >>> sh;
        y       = shifted[63:0];
    end
endmodule : scale_mul

// file: logic/bus_object_format_codec.sv
// Functional notes
// - signed values are two's complement, sign on top
// - sign clear positive or zero, set negative
// - unsigned plain binary, high word first
// - 16-bit fixed point has six fraction bits
// - 32-bit milli format counts thousandths
// - scaled formats are signed ints times factor
// - separate factor per quantity and width
// - factor bit 5 clear selects decimal base
// - bits 4..0 exponent, decimal n up to 9
// - bit 5 set gives binary, n up to 24
// - factor bits 15..6 reserved, no meaning
// - bit string is sixteen independent bits
// - octet string length known per transfer
`include "codec_map.svh"

module bus_object_format_codec (
    // clock, reset, enable
    input  wire logic             mclk,
    input  wire logic             rst_b,
    input  wire logic             cen,
    // factor object port
    input  wire logic             obj_wr,
    input  wire logic             obj_rd,
    input  wire logic [2:0]       obj_sel,
    input  wire logic [15:0]      obj_wdata,
    output logic      [15:0]      obj_rdata,
    output logic                  obj_rvalid,
    // conversion request
    input  wire logic             req_valid,
    input  wire logic             req_encode,
    input  wire codec_pkg::fmt_t  req_fmt,
    input  wire logic [1:0]       req_qty,
    input  wire logic [15:0]      req_bus_first,
    input  wire logic [15:0]      req_bus_second,
    input  wire logic [63:0]      req_value,
    // conversion result
    output logic                  res_valid,
    output logic                  res_err,
    output logic      [63:0]      res_value,
    output logic      [15:0]      res_bus_first,
    output logic      [15:0]      res_bus_second,
    // octet string stream
    input  wire logic             oct_start,
    input  wire logic [7:0]       oct_len,
    input  wire logic             oct_in_valid,
    input  wire logic [7:0]       oct_in_byte,
    output logic                  oct_out_valid,
    output logic      [7:0]       oct_out_byte,
    output logic                  oct_out_last,
    output logic                  oct_err
);
    codec_pkg::codec_state_t st_q;
    codec_pkg::codec_state_t st_d;
    logic        [63:0] mul_y;
    logic        [2:0]  fac_idx;
    logic        [15:0] fac_sel;
    logic               qty_bad;
    logic               is_scaled;
    logic               ex_bad;
    logic        [4:0]  ne;
    logic        [63:0] a0;
    logic        [33:0] k0;
    logic        [5:0]  sh0;

    // bus words to a sign or zero extended integer
    function automatic logic [63:0] from_bus(codec_pkg::fmt_t f, logic [15:0] w1,
                                             logic [15:0] w2);
        case (f)
            codec_pkg::INT8:          from_bus = {{56{w1[7]}}, w1[7:0]};
            codec_pkg::UINT8:         from_bus = {56'h0, w1[7:0]};
            codec_pkg::INT16,
            codec_pkg::FIXED16_SIX,
            codec_pkg::SCALED_INT16:  from_bus = {{48{w1[15]}}, w1};
            codec_pkg::UINT16,
            codec_pkg::BIT_STRING16:  from_bus = {48'h0, w1};
            codec_pkg::INT32,
            codec_pkg::FIXED32_MILLI,
            codec_pkg::SCALED_INT32:  from_bus = {{32{w1[15]}}, w1, w2};
            codec_pkg::UINT32:        from_bus = {32'h0, w1, w2};
            default:                  from_bus = 64'h0;
        endcase
    endfunction : from_bus

    // does an encoded integer fit its bus width
    function automatic logic fits(codec_pkg::fmt_t f, logic [63:0] y);
        case (f)
            codec_pkg::INT8:          fits = (&y[63:7]) | ~(|y[63:7]);
            codec_pkg::UINT8:         fits = ~(|y[63:8]);
            codec_pkg::INT16,
            codec_pkg::FIXED16_SIX,
            codec_pkg::SCALED_INT16:  fits = (&y[63:15]) | ~(|y[63:15]);
            codec_pkg::UINT16:        fits = ~(|y[63:16]);
            codec_pkg::BIT_STRING16:  fits = 1'b1;
            codec_pkg::INT32,
            codec_pkg::FIXED32_MILLI,
            codec_pkg::SCALED_INT32:  fits = (&y[63:31]) | ~(|y[63:31]);
            codec_pkg::UINT32:        fits = ~(|y[63:32]);
            default:                  fits = 1'b0;
        endcase
    endfunction : fits

    // integer to bus words, first transferred word on top
    function automatic logic [31:0] to_bus(codec_pkg::fmt_t f, logic [63:0] y);
        case (f)
            codec_pkg::INT8,
            codec_pkg::UINT8:         to_bus = {8'h00, y[7:0], 16'h0000};
            codec_pkg::INT32,
            codec_pkg::UINT32,
            codec_pkg::FIXED32_MILLI,
            codec_pkg::SCALED_INT32:  to_bus = y[31:0];
            default:                  to_bus = {y[15:0], 16'h0000};
        endcase
    endfunction : to_bus

    // 10^-n in Q32.32, rounded to nearest
    function automatic logic [33:0] dec_q32(logic [4:0] n);
        case (n)
            5'h00:   dec_q32 = 34'h100000000;
            5'h01:   dec_q32 = 34'h01999999A;
            5'h02:   dec_q32 = 34'h0028F5C29;
            5'h03:   dec_q32 = 34'h000418937;
            5'h04:   dec_q32 = 34'h000068DB9;
            5'h05:   dec_q32 = 34'h00000A7C6;
            5'h06:   dec_q32 = 34'h0000010C7;
            5'h07:   dec_q32 = 34'h0000001AD;
            5'h08:   dec_q32 = 34'h00000002B;
            default: dec_q32 = 34'h000000004;
        endcase
    endfunction : dec_q32

    // 10^n as an integer for encoding
    function automatic logic [33:0] dec_pow(logic [4:0] n);
        case (n)
            5'h00:   dec_pow = 34'h000000001;
            5'h01:   dec_pow = 34'h00000000A;
            5'h02:   dec_pow = 34'h000000064;
            5'h03:   dec_pow = 34'h0000003E8;
            5'h04:   dec_pow = 34'h000002710;
            5'h05:   dec_pow = 34'h0000186A0;
            5'h06:   dec_pow = 34'h0000F4240;
            5'h07:   dec_pow = 34'h000989680;
            5'h08:   dec_pow = 34'h005F5E100;
            default: dec_pow = 34'h03B9ACA00;
        endcase
    endfunction : dec_pow

    scale_mul u_mul (
        .a  (st_q.s1_a),
        .k  (st_q.s1_k),
        .sh (st_q.s1_sh),
        .y  (mul_y)
    );

    // factor lookup; an unused quantity code reads as factor 1 and flags an error
    always_comb begin
        is_scaled = (req_fmt == codec_pkg::SCALED_INT16) ||
                    (req_fmt == codec_pkg::SCALED_INT32);
        qty_bad   = (req_qty == 2'h3);
        fac_idx   = (req_fmt == codec_pkg::SCALED_INT32) ? 3'({1'b0, req_qty}) + `SEL_S32_SPEED
                                                         : 3'({1'b0, req_qty});
        fac_sel   = qty_bad ? `FAC_RST : st_q.fac[fac_idx];
        // only bits 5..0 take part, reserved bits are ignored
        ex_bad    = fac_sel[`FAC_BASE_BIT] ? (fac_sel[`FAC_EXP_MSB:0] > `BIN_EXP_MAX)
                                           : (fac_sel[`FAC_EXP_MSB:0] > `DEC_EXP_MAX);
        ne        = ex_bad ? 5'h00 : fac_sel[`FAC_EXP_MSB:0];
    end

    // operand selection for the shared multiplier
    always_comb begin
        a0  = req_encode ? req_value : from_bus(req_fmt, req_bus_first, req_bus_second);
        k0  = req_encode ? `K_ONE : `K_Q_ONE;
        sh0 = req_encode ? `Q_FRAC : 6'h00;
        case (req_fmt)
            codec_pkg::FIXED16_SIX: begin
                k0  = req_encode ? `K_ONE : `K_FIX16_DEC;
                sh0 = req_encode ? (`Q_FRAC - `FIX16_FRAC) : 6'h00;
            end
            codec_pkg::FIXED32_MILLI: begin
                k0  = req_encode ? `K_MILLI_ENC : `K_MILLI_DEC;
            end
            codec_pkg::SCALED_INT16,
            codec_pkg::SCALED_INT32: begin
                if (fac_sel[`FAC_BASE_BIT]) begin
                    // binary base: plain shifts, exact both ways
                    k0  = req_encode ? `K_ONE : (`K_Q_ONE >> ne);
                    sh0 = req_encode ? (`Q_FRAC - 6'({1'b0, ne})) : 6'h00;
                end else begin
                    k0  = req_encode ? dec_pow(ne) : dec_q32(ne);
                end
            end
            codec_pkg::BIT_STRING16: begin
                // bits stay in place, never scaled
                k0  = `K_ONE;
                sh0 = 6'h00;
            end
            default: ;
        endcase
    end

    // next state
    always_comb begin
        st_d         = st_q;
        st_d.rd_vld  = 1'b0;
        st_d.s1_vld  = 1'b0;
        st_d.res_vld = 1'b0;
        st_d.oct_vld = 1'b0;
        st_d.oct_last = 1'b0;
        st_d.oct_err = 1'b0;
        // factor objects; reserved bits are stored as zero
        if (obj_wr && (obj_sel < `SEL_COUNT)) begin
            st_d.fac[obj_sel] = obj_wdata & `FAC_WRITE_MASK;
        end
        if (obj_rd) begin
            st_d.rd_vld  = 1'b1;
            st_d.rd_data = (obj_sel < `SEL_COUNT) ? st_q.fac[obj_sel] : 16'h0000;
        end
        // stage 1: capture operands
        if (req_valid) begin
            st_d.s1_vld = 1'b1;
            st_d.s1_enc = req_encode;
            st_d.s1_fmt = req_fmt;
            st_d.s1_a   = a0;
            st_d.s1_k   = k0;
            st_d.s1_sh  = sh0;
            st_d.s1_err = (is_scaled && (ex_bad || qty_bad)) ||
                          (req_fmt > codec_pkg::BIT_STRING16);
        end
        // stage 2: result and range check
        if (st_q.s1_vld) begin
            st_d.res_vld = 1'b1;
            st_d.res     = mul_y;
            st_d.res_err = st_q.s1_err || (st_q.s1_enc && !fits(st_q.s1_fmt, mul_y));
            {st_d.bus_first, st_d.bus_second} = to_bus(st_q.s1_fmt, mul_y);
        end
        // octet string: the length is announced first, bytes then counted down
        if (oct_start) begin
            st_d.oct_open = (oct_len != 8'h00);
            st_d.oct_left = oct_len;
        end else if (oct_in_valid) begin
            if (st_q.oct_open) begin
                st_d.oct_vld  = 1'b1;
                st_d.oct_byte = oct_in_byte;
                st_d.oct_left = st_q.oct_left - 8'h01;
                st_d.oct_last = (st_q.oct_left == 8'h01);
                st_d.oct_open = (st_q.oct_left != 8'h01);
            end else begin
                st_d.oct_err = 1'b1; // byte outside an announced string
            end
        end
    end

    // single register for all state; reset wins over a low enable
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            st_q <= '0;
            for (int i = 0; i < 6; i++) begin
                st_q.fac[i] <= `FAC_RST;
            end
        end else if (cen) begin
            st_q <= st_d;
        end
    end

    assign obj_rdata      = st_q.rd_data;
    assign obj_rvalid     = st_q.rd_vld;
    assign res_valid      = st_q.res_vld;
    assign res_err        = st_q.res_err;
    assign res_value      = st_q.res;
    assign res_bus_first  = st_q.bus_first;
    assign res_bus_second = st_q.bus_second;
    assign oct_out_valid  = st_q.oct_vld;
    assign oct_out_byte   = st_q.oct_byte;
    assign oct_out_last   = st_q.oct_last;
    assign oct_err        = st_q.oct_err;

    // int16 decode sign-extends into the integer part
    property p_int16_sign;
        @(posedge mclk) disable iff (!rst_b)
        (cen && req_valid && !req_encode && req_fmt == codec_pkg::INT16) ##1 cen
        |=> res_value == {{16{$past(req_bus_first[15], 2)}}, $past(req_bus_first, 2), 32'h0};
    endproperty
    a_int16_sign: assert property (p_int16_sign) else $error("int16 decode wrong");

    // a set sign bit gives a negative result
    property p_int32_neg;
        @(posedge mclk) disable iff (!rst_b)
        (cen && req_valid && !req_encode && req_fmt == codec_pkg::INT32) ##1 cen
        |=> res_value[63] == $past(req_bus_first[15], 2);
    endproperty
    a_int32_neg: assert property (p_int32_neg) else $error("int32 sign wrong");

    // unsigned 32: first word is the high word, no sign
    property p_uint32_order;
        @(posedge mclk) disable iff (!rst_b)
        (cen && req_valid && !req_encode && req_fmt == codec_pkg::UINT32) ##1 cen
        |=> res_value == {$past(req_bus_first, 2), $past(req_bus_second, 2), 32'h0};
    endproperty
    a_uint32_order: assert property (p_uint32_order) else $error("uint32 order wrong");

    // raw 0x4000 is 256.0
    property p_fix16_256;
        @(posedge mclk) disable iff (!rst_b)
        (cen && req_valid && !req_encode && req_fmt == codec_pkg::FIXED16_SIX &&
         req_bus_first == 16'h4000) ##1 cen
        |=> res_valid && res_value == 64'h0000_0100_0000_0000;
    endproperty
    a_fix16_256: assert property (p_fix16_256) else $error("fixed16 scale wrong");

    // 1.0 encodes to 1000 counts
    property p_milli_one;
        @(posedge mclk) disable iff (!rst_b)
        (cen && req_valid && req_encode && req_fmt == codec_pkg::FIXED32_MILLI &&
         req_value == 64'h0000_0001_0000_0000) ##1 cen
        |=> !res_err && res_bus_first == 16'h0000 && res_bus_second == 16'h03E8;
    endproperty
    a_milli_one: assert property (p_milli_one) else $error("milli encode wrong");

    // scaled16 with unity factor equals int16
    property p_scaled_unity;
        @(posedge mclk) disable iff (!rst_b)
        (cen && req_valid && !req_encode && req_fmt == codec_pkg::SCALED_INT16 &&
         !qty_bad && fac_sel[5:0] == 6'h00) ##1 cen
        |=> !res_err && res_value[63:32] == {{16{$past(req_bus_first[15], 2)}},
                                             $past(req_bus_first, 2)};
    endproperty
    a_scaled_unity: assert property (p_scaled_unity) else $error("unity scale wrong");

    // each quantity reads its own factor register
    property p_fac_pick;
        @(posedge mclk) disable iff (!rst_b)
        (req_fmt == codec_pkg::SCALED_INT32 && req_qty == 2'h1)
        |-> fac_sel == st_q.fac[4];
    endproperty
    a_fac_pick: assert property (p_fac_pick) else $error("factor select wrong");

    // decimal exponent above 9 is an error
    property p_dec_range;
        @(posedge mclk) disable iff (!rst_b)
        (cen && req_valid && is_scaled && !fac_sel[5] && fac_sel[4:0] == 5'h0A)
        |=> st_q.s1_err;
    endproperty
    a_dec_range: assert property (p_dec_range) else $error("decimal range");

    // decimal n=3 decodes with one thousandth
    property p_dec_k;
        @(posedge mclk) disable iff (!rst_b)
        (cen && req_valid && !req_encode && is_scaled && !qty_bad && fac_sel[5:0] == 6'h03)
        |=> st_q.s1_k == 34'h000418937 && !st_q.s1_err;
    endproperty
    a_dec_k: assert property (p_dec_k) else $error("decimal factor wrong");

    // binary n=24 is the deepest legal shift, n=25 is refused
    property p_bin_k;
        @(posedge mclk) disable iff (!rst_b)
        (cen && req_valid && !req_encode && is_scaled && !qty_bad && fac_sel[5:0] == 6'h38)
        |=> st_q.s1_k == 34'h000000100 && !st_q.s1_err;
    endproperty
    a_bin_k: assert property (p_bin_k) else $error("binary factor wrong");

    // stored factor keeps only bits 5..0
    property p_fac_store;
        @(posedge mclk) disable iff (!rst_b)
        (cen && obj_wr && obj_sel < 3'h6)
        |=> st_q.fac[$past(obj_sel)] == {10'h000, $past(obj_wdata[5:0])};
    endproperty
    a_fac_store: assert property (p_fac_store) else $error("reserved bits kept");

    // bit string passes through untouched
    property p_bits;
        @(posedge mclk) disable iff (!rst_b)
        (cen && req_valid && req_encode && req_fmt == codec_pkg::BIT_STRING16) ##1 cen
        |=> !res_err && res_bus_first == $past(req_value[15:0], 2);
    endproperty
    a_bits: assert property (p_bits) else $error("bit string altered");

    // last byte of an announced string is marked
    property p_oct_last;
        @(posedge mclk) disable iff (!rst_b)
        (cen && !oct_start && oct_in_valid && st_q.oct_open && st_q.oct_left == 8'h01)
        |=> oct_out_valid && oct_out_last && !st_q.oct_open;
    endproperty
    a_oct_last: assert property (p_oct_last) else $error("octet last missing");
endmodule : bus_object_format_codec

// file: test/fieldbus_master_model.sv
// master side of the octet string stream
module fieldbus_master_model (
    // clock
    input  wire logic       mclk,
    // octet string lines toward the codec
    output logic            oct_start,
    output logic [7:0]      oct_len,
    output logic            oct_in_valid,
    output logic [7:0]      oct_in_byte
);
    timeunit 1ns;
    timeprecision 1ps;

    // quiet lines from time zero
    initial begin
        oct_start    = 1'h0;
        oct_len      = 8'h00;
        oct_in_valid = 1'h0;
        oct_in_byte  = 8'h00;
    end

    // length goes with the start pulse; extra bytes beyond it are a deliberate fault
    task automatic send(input logic [7:0] len, input logic [7:0] base, input int extra);
        @(posedge mclk);
        oct_start <= 1'h1;
        oct_len   <= len;
        @(posedge mclk);
        oct_start <= 1'h0;
        for (int i = 0; i < len + extra; i++) begin
            oct_in_valid <= 1'h1;
            oct_in_byte  <= base + i[7:0];
            @(posedge mclk);
        end
        // released data shows the inverse so a stale byte never passes as fresh
        oct_in_valid <= 1'h0;
        oct_in_byte  <= ~oct_in_byte;
    endtask : send
endmodule : fieldbus_master_model

// file: test/bus_object_format_codec_bench.sv
module bus_object_format_codec_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic            mclk, rst_b, cen, obj_wr, obj_rd, obj_rvalid, req_valid, req_encode;
    logic            res_valid, res_err, oct_start, oct_in_valid, oct_out_valid;
    logic            oct_out_last, oct_err;
    logic [1:0]      req_qty;
    logic [2:0]      obj_sel;
    logic [7:0]      oct_len, oct_in_byte, oct_out_byte;
    logic [15:0]     obj_wdata, obj_rdata, req_bus_first, req_bus_second;
    logic [15:0]     res_bus_first, res_bus_second;
    logic [63:0]     req_value, res_value;
    codec_pkg::fmt_t req_fmt;
    int              failures = 0;
    int              checks = 0;

    bus_object_format_codec bus_object_format_codec_inst (
        .mclk, .rst_b, .cen, .obj_wr, .obj_rd, .obj_sel, .obj_wdata, .obj_rdata,
        .obj_rvalid, .req_valid, .req_encode, .req_fmt, .req_qty, .req_bus_first,
        .req_bus_second, .req_value, .res_valid, .res_err, .res_value, .res_bus_first,
        .res_bus_second, .oct_start, .oct_len, .oct_in_valid, .oct_in_byte,
        .oct_out_valid, .oct_out_byte, .oct_out_last, .oct_err
    );

    fieldbus_master_model fieldbus_master_model_inst (
        .mclk, .oct_start, .oct_len, .oct_in_valid, .oct_in_byte
    );

    // free running clock
    initial begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish

    task automatic wr(input logic [2:0] s, input logic [15:0] d);
        @(posedge mclk);
        obj_wr    <= 1'h1;
        obj_sel   <= s;
        obj_wdata <= d;
        @(posedge mclk);
        obj_wr    <= 1'h0;
    endtask : wr

    // read answer comes exactly one edge after the take
    task automatic rd(input logic [2:0] s, input logic [15:0] e);
        @(posedge mclk);
        obj_rd  <= 1'h1;
        obj_sel <= s;
        @(posedge mclk);
        obj_rd  <= 1'h0;
        #1;
        chk(obj_rvalid, 1'h1);
        chk(obj_rdata, e);
    endtask : rd

    // decode takes the bus words from x[31:0], encode takes x as the value
    task automatic conv(input logic enc, input logic [3:0] f, input logic [1:0] q,
                        input logic [63:0] x, input logic [63:0] e, input logic err);
        logic wide;
        wide = f == codec_pkg::INT32 || f == codec_pkg::UINT32 ||
               f == codec_pkg::FIXED32_MILLI || f == codec_pkg::SCALED_INT32;
        @(posedge mclk);
        req_valid      <= 1'h1;
        req_encode     <= enc;
        req_fmt        <= codec_pkg::fmt_t'(f);
        req_qty        <= q;
        req_bus_first  <= x[31:16];
        req_bus_second <= x[15:0];
        req_value      <= x;
        @(posedge mclk);
        req_valid      <= 1'h0;
        @(posedge mclk);
        #1;
        chk(res_valid, 1'h1);
        chk(res_err, err);
        if (!err) begin
            chk(enc ? (wide ? {32'h0, res_bus_first, res_bus_second}
                            : {48'h0, res_bus_first}) : res_value, e);
        end
    endtask : conv

    // main sequence: reset, factor objects, conversions, octet strings
    initial begin
        int n;
        int errs;
        n = 0;
        errs = 0;
        {rst_b, obj_wr, obj_rd, req_valid, req_encode, req_qty, obj_sel} = 10'h000;
        {obj_wdata, req_bus_first, req_bus_second, req_value} = 112'h0;
        req_fmt = codec_pkg::INT8;
        cen = 1'h1;
        repeat (4) @(posedge mclk);
        rst_b <= 1'h1;
        for (int s = 0; s < 8; s++) rd(s[2:0], 16'h0000);
        wr(3'h4, 16'hFFE3);
        rd(3'h4, 16'h0023);
        wr(3'h6, 16'h0021);
        rd(3'h6, 16'h0000);
        $display("test objects done");
        conv(1'h0, codec_pkg::INT8, 2'h0, 64'h00FF0000, 64'hFFFFFFFF00000000, 1'h0);
        conv(1'h0, codec_pkg::INT8, 2'h0, 64'h007F0000, 64'h0000007F00000000, 1'h0);
        conv(1'h0, codec_pkg::UINT8, 2'h0, 64'h00FF0000, 64'h000000FF00000000, 1'h0);
        conv(1'h0, codec_pkg::INT16, 2'h0, 64'h80000000, 64'hFFFF800000000000, 1'h0);
        conv(1'h0, codec_pkg::UINT16, 2'h0, 64'h80000000, 64'h0000800000000000, 1'h0);
        conv(1'h0, codec_pkg::INT32, 2'h0, 64'hFFFFFFFE, 64'hFFFFFFFE00000000, 1'h0);
        conv(1'h0, codec_pkg::UINT32, 2'h0, 64'h00010002, 64'h0001000200000000, 1'h0);
        conv(1'h0, codec_pkg::FIXED16_SIX, 2'h0, 64'h40000000, 64'h0000010000000000, 1'h0);
        conv(1'h0, codec_pkg::FIXED16_SIX, 2'h0, 64'hFFC00000, 64'hFFFFFFFF00000000, 1'h0);
        conv(1'h0, codec_pkg::BIT_STRING16, 2'h0, 64'hA5C30000, 64'h000000000000A5C3, 1'h0);
        conv(1'h1, codec_pkg::FIXED32_MILLI, 2'h0, 64'h0000000100000000, 64'h03E8, 1'h0);
        conv(1'h1, codec_pkg::FIXED32_MILLI, 2'h0, 64'hFFFFFFFF00000000, 64'hFFFFFC18, 1'h0);
        conv(1'h1, codec_pkg::INT8, 2'h0, 64'hFFFFFFFE00000000, 64'h00FE, 1'h0);
        conv(1'h1, codec_pkg::INT32, 2'h0, 64'h7FFFFFFF00000000, 64'h7FFFFFFF, 1'h0);
        conv(1'h1, codec_pkg::UINT16, 2'h0, 64'hFFFFFFFF00000000, 64'h0, 1'h1);
        conv(1'h1, codec_pkg::FIXED16_SIX, 2'h0, 64'hFFFFFFFF00000000, 64'hFFC0, 1'h0);
        conv(1'h1, codec_pkg::BIT_STRING16, 2'h0, 64'h5A3C, 64'h5A3C, 1'h0);
        conv(1'h1, 4'hB, 2'h0, 64'h0, 64'h0, 1'h1);
        $display("test plain formats done");
        wr(3'h0, 16'hFFE1);
        wr(3'h2, 16'h0001);
        wr(3'h4, 16'h0038);
        wr(3'h5, 16'h0009);
        conv(1'h0, codec_pkg::SCALED_INT16, 2'h0, 64'h00040000, 64'h200000000, 1'h0);
        conv(1'h1, codec_pkg::SCALED_INT16, 2'h0, 64'h300000000, 64'h0006, 1'h0);
        conv(1'h1, codec_pkg::SCALED_INT16, 2'h2, 64'h300000000, 64'h001E, 1'h0);
        conv(1'h0, codec_pkg::SCALED_INT32, 2'h1, 64'h01000000, 64'h100000000, 1'h0);
        conv(1'h1, codec_pkg::SCALED_INT32, 2'h2, 64'h200000000, 64'h77359400, 1'h0);
        conv(1'h0, codec_pkg::SCALED_INT32, 2'h0, 64'h00000005, 64'h500000000, 1'h0);
        conv(1'h0, codec_pkg::SCALED_INT16, 2'h1, 64'hFFFB0000, 64'hFFFFFFFB00000000, 1'h0);
        conv(1'h0, codec_pkg::SCALED_INT16, 2'h3, 64'h0, 64'h0, 1'h1);
        wr(3'h4, 16'h0039);
        wr(3'h5, 16'h000A);
        conv(1'h0, codec_pkg::SCALED_INT32, 2'h1, 64'h1, 64'h0, 1'h1);
        conv(1'h0, codec_pkg::SCALED_INT32, 2'h2, 64'h1, 64'h0, 1'h1);
        // decimal n=3 decode uses the rounded thousandth, so 1000 lands just under 1.0
        wr(3'h3, 16'h0003);
        conv(1'h0, codec_pkg::SCALED_INT32, 2'h0, 64'h000003E8, 64'hFFFFFED8, 1'h0);
        // a write while the enable is low must not land
        @(posedge mclk);
        cen <= 1'h0;
        wr(3'h3, 16'h0005);
        @(posedge mclk);
        cen <= 1'h1;
        rd(3'h3, 16'h0003);
        $display("test scaled formats done");
        // one byte too many: the codec must flag it once the string has closed
        fork
            fieldbus_master_model_inst.send(8'h03, 8'hA0, 1);
            for (int i = 0; i < 10; i++) begin
                @(posedge mclk);
                #1;
                if (oct_out_valid === 1'h1) begin
                    chk(oct_out_byte, 8'hA0 + n);
                    chk(oct_out_last, n == 2);
                    n++;
                end
                errs += (oct_err === 1'h1);
            end
        join
        chk(n, 3);
        chk(errs, 1);
        $display("test octet string done");
        tally_and_finish();
    end
endmodule : bus_object_format_codec_bench
